// File: common/wwdt_pkg.sv
// Package of offsets, fields, reset values and timing for the windowed watchdog
package wwdt_pkg;
    // ------------------------------------------------------------
    // Register map (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_RESTART_CONTROL = 8'h00;
    localparam logic [7:0] ADDR_WATCHDOG_MODE = 8'h04;
    localparam logic [7:0] ADDR_FAULT_STATUS = 8'h08;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h0C;
    // ------------------------------------------------------------
    // Restart control fields
    // ------------------------------------------------------------
    localparam int KEY_MSB = 31;
    localparam int KEY_LSB = 24;
    localparam logic [7:0] RESTART_KEY = 8'hA5;
    localparam int RESTART_CMD_BIT = 0;
    // ------------------------------------------------------------
    // Mode fields
    // ------------------------------------------------------------
    localparam int RELOAD_MSB = 11;
    localparam int RELOAD_LSB = 0;
    localparam int IRQ_EN_BIT = 12;
    localparam int RST_EN_BIT = 13;
    localparam int PROC_ONLY_BIT = 14;
    localparam int TIMER_OFF_BIT = 15;
    localparam int WINDOW_MSB = 27;
    localparam int WINDOW_LSB = 16;
    localparam int HALT_DBG_BIT = 28;
    localparam int HALT_IDLE_BIT = 29;
    localparam logic [31:0] MODE_RESET = 32'h3FFF_2FFF;
    localparam logic [31:0] MODE_MASK = 32'h3FFF_FFFF;
    // ------------------------------------------------------------
    // Status fields
    // ------------------------------------------------------------
    localparam int UNF_BIT = 0;
    localparam int ERR_BIT = 1;
    localparam logic [1:0] MASK_RESET = 2'h3;
    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int PRESCALE_DIV = 128;
    localparam logic [6:0] PRESCALE_LAST = 7'(PRESCALE_DIV - 1);
endpackage

// File: src/wwdt_sync.sv
// Two-stage synchroniser for a group of asynchronous levels
`timescale 1ns/1ps
module wwdt_sync #(
    parameter int W = 3
) (
    input wire logic clk_sys_i,
    input wire logic sys_rst_i,
    input wire logic [W-1:0] async_i,
    output logic [W-1:0] sync_o
);
    logic [W-1:0] meta_r;
    logic [W-1:0] sync_r;

    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            meta_r <= '0;
            sync_r <= '0;
        end else begin
            meta_r <= async_i;
            sync_r <= meta_r;
        end
    end

    assign sync_o = sync_r;
endmodule

// File: src/wwdt_top.sv
// Windowed watchdog timer with APB register slave
//
// What this block does
// (RULE1) Control write needs key 0xA5, else ignored
// (RULE2) Reload field loads the 12-bit counter
// (RULE3) Irq enable lets faults raise interrupt
// (RULE4) Reset enable lets faults request reset
// (RULE5) Select bit: one processor-only, zero all
// (RULE6) Restart accepted only when count within window
// (RULE7) Restart above window limit is error fault
// (RULE8) Debug halt bit stops counting in debug
// (RULE9) Idle halt bit stops counting in idle
// (RULE10) Timer off bit disables the watchdog
// (RULE11) Software keeps fields stable after restart
// (RULE12) Underflow flag sticky until status read or a status write of one to its bit
// (RULE13) Restart error flag sticky until status read or a status write of one to its bit
// (RULE14) Mode register write-once; write restarts counter
// (RULE15) Counter decrements per slow clock over 128
// (RULE16) Restart reloads counter and clears prescaler
// (RULE17) Status read clears flags, irq, fault line
// (RULE18) Disabled: no counting, window errors still flagged
// (RULE19) Underflow when zero count meets tick
//
// The address map and the APB slave port were chosen for this implementation.
`timescale 1ns/1ps
module wwdt_top (
    input wire logic clk_sys_i,
    input wire logic sys_rst_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    input wire logic slow_clk_i,
    input wire logic cpu_debug_i,
    input wire logic sys_idle_i,
    output logic irq_o,
    output logic fault_o,
    output logic fault_proc_only_o
);
    // ------------------------------------------------------------
    // Input synchronisation and slow clock edge
    // ------------------------------------------------------------
    logic [2:0] sync_w;
    logic slow_d_r;
    logic slow_d_nxt;
    logic slow_tick;

    wwdt_sync #(.W(3)) u_sync (
        .clk_sys_i(clk_sys_i),
        .sys_rst_i(sys_rst_i),
        .async_i({sys_idle_i, cpu_debug_i, slow_clk_i}),
        .sync_o(sync_w)
    );

    // Rising edge of the synchronised slow clock, one system cycle long
    always_comb begin
        slow_d_nxt = sync_w[0];
        slow_tick = sync_w[0] & ~slow_d_r;
    end

    // ------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------
    logic access;
    logic wr_ctl;
    logic wr_mode;
    logic rd_stat;
    logic wr_stat;
    logic wr_mask;
    logic addr_ok;

    always_comb begin
        access = psel_i & penable_i;
        addr_ok = (paddr_i == wwdt_pkg::ADDR_RESTART_CONTROL)
            | (paddr_i == wwdt_pkg::ADDR_WATCHDOG_MODE)
            | (paddr_i == wwdt_pkg::ADDR_FAULT_STATUS)
            | (paddr_i == wwdt_pkg::ADDR_IRQ_MASK);
        wr_ctl = access & pwrite_i & (paddr_i == wwdt_pkg::ADDR_RESTART_CONTROL);
        wr_mode = access & pwrite_i & (paddr_i == wwdt_pkg::ADDR_WATCHDOG_MODE);
        wr_stat = access & pwrite_i & (paddr_i == wwdt_pkg::ADDR_FAULT_STATUS);
        wr_mask = access & pwrite_i & (paddr_i == wwdt_pkg::ADDR_IRQ_MASK);
        rd_stat = access & ~pwrite_i & (paddr_i == wwdt_pkg::ADDR_FAULT_STATUS);
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic [31:0] mode_r;
    logic [31:0] mode_nxt;
    logic mode_locked_r;
    logic mode_locked_nxt;
    logic [11:0] count_r;
    logic [11:0] count_nxt;
    logic [6:0] presc_r;
    logic [6:0] presc_nxt;
    logic [1:0] stat_r;
    logic [1:0] stat_nxt;
    logic [1:0] mask_r;
    logic [1:0] mask_nxt;
    logic fault_r;
    logic fault_nxt;
    logic irq_r;
    logic irq_nxt;
    logic proc_only_r;
    logic proc_only_nxt;
    logic [31:0] prdata_r;
    logic [31:0] prdata_nxt;
    logic pslverr_r;
    logic pslverr_nxt;
    logic pready_r;

    // ------------------------------------------------------------
    // Watchdog core
    // ------------------------------------------------------------
    logic [11:0] reload_val;
    logic [11:0] window_lim;
    logic timer_off;
    logic halted;
    logic restart_req;
    logic restart_ok;
    logic restart_err;
    logic div_tick;
    logic underflow;
    logic load;
    logic [1:0] events;

    always_comb begin
        reload_val = mode_r[wwdt_pkg::RELOAD_MSB:wwdt_pkg::RELOAD_LSB]; // see (RULE2)
        window_lim = mode_r[wwdt_pkg::WINDOW_MSB:wwdt_pkg::WINDOW_LSB];
        timer_off = mode_r[wwdt_pkg::TIMER_OFF_BIT]; // see (RULE10)
        halted = (mode_r[wwdt_pkg::HALT_DBG_BIT] & sync_w[1]) // see (RULE8)
            | (mode_r[wwdt_pkg::HALT_IDLE_BIT] & sync_w[2]); // see (RULE9)
        // Key must match or the whole write is dropped
        restart_req = wr_ctl & pready_r & pwdata_i[wwdt_pkg::RESTART_CMD_BIT]
            & (pwdata_i[wwdt_pkg::KEY_MSB:wwdt_pkg::KEY_LSB]
            == wwdt_pkg::RESTART_KEY); // see (RULE1)
        restart_ok = restart_req & (count_r <= window_lim); // see (RULE6)
        // Window check stays live when the timer is off
        restart_err = restart_req & (count_r > window_lim); // see (RULE7) (RULE18)
        div_tick = slow_tick & ~timer_off & ~halted & (presc_r == wwdt_pkg::PRESCALE_LAST);
        underflow = div_tick & (count_r == 12'h000); // see (RULE19)
        load = restart_ok | (wr_mode & pready_r & ~mode_locked_r);
    end

    always_comb begin
        mode_nxt = mode_r;
        mode_locked_nxt = mode_locked_r;
        count_nxt = count_r;
        presc_nxt = presc_r;
        // Only the first mode write after reset lands
        if (wr_mode && pready_r && !mode_locked_r) begin // see (RULE14)
            mode_nxt = pwdata_i & wwdt_pkg::MODE_MASK;
            mode_locked_nxt = 1'b1;
            count_nxt = pwdata_i[wwdt_pkg::RELOAD_MSB:wwdt_pkg::RELOAD_LSB];
            presc_nxt = 7'h00;
        end else if (restart_ok) begin
            count_nxt = reload_val; // see (RULE16)
            presc_nxt = 7'h00; // see (RULE16)
        end else if (slow_tick && !timer_off && !halted) begin // see (RULE18)
            presc_nxt = presc_r + 7'h01; // see (RULE15)
            if (div_tick) begin
                count_nxt = count_r - 12'h001; // see (RULE15)
            end
        end
    end

    // ------------------------------------------------------------
    // Fault flags, interrupt and reset request
    // ------------------------------------------------------------
    always_comb begin
        events = 2'h0;
        events[wwdt_pkg::UNF_BIT] = underflow;
        events[wwdt_pkg::ERR_BIT] = restart_err;
        stat_nxt = stat_r;
        // A read clears only what it reported, so an event after the capture is kept
        if (rd_stat && pready_r) begin // see (RULE17)
            stat_nxt = stat_r & ~prdata_r[1:0];
        end else if (wr_stat && pready_r) begin
            stat_nxt = stat_r & ~pwdata_i[1:0];
        end
        stat_nxt = stat_nxt | events; // see (RULE12) (RULE13)
        mask_nxt = mask_r;
        if (wr_mask && pready_r) begin
            mask_nxt = pwdata_i[1:0];
        end
        irq_nxt = mode_r[wwdt_pkg::IRQ_EN_BIT] & |(stat_nxt & mask_r); // see (RULE3)
        fault_nxt = fault_r;
        proc_only_nxt = proc_only_r;
        if (rd_stat && pready_r) begin
            fault_nxt = 1'b0; // see (RULE17)
        end
        if ((|events) && mode_r[wwdt_pkg::RST_EN_BIT]) begin // see (RULE4)
            fault_nxt = 1'b1;
            proc_only_nxt = mode_r[wwdt_pkg::PROC_ONLY_BIT]; // see (RULE5)
        end
    end

    // ------------------------------------------------------------
    // APB answer: one wait state, reads registered
    // ------------------------------------------------------------
    always_comb begin
        prdata_nxt = 32'h0000_0000;
        pslverr_nxt = 1'b0;
        if (psel_i && penable_i && !pready_r) begin
            pslverr_nxt = ~addr_ok;
            if (!pwrite_i) begin
                case (paddr_i)
                    wwdt_pkg::ADDR_WATCHDOG_MODE: prdata_nxt = mode_r;
                    wwdt_pkg::ADDR_FAULT_STATUS: prdata_nxt = {30'h0, stat_r};
                    wwdt_pkg::ADDR_IRQ_MASK: prdata_nxt = {30'h0, mask_r};
                    default: prdata_nxt = 32'h0000_0000;
                endcase
            end
        end
    end

    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            slow_d_r <= 1'b0;
            mode_r <= wwdt_pkg::MODE_RESET;
            mode_locked_r <= 1'b0;
            count_r <= 12'hFFF;
            presc_r <= 7'h00;
            stat_r <= 2'h0;
            mask_r <= wwdt_pkg::MASK_RESET;
            fault_r <= 1'b0;
            irq_r <= 1'b0;
            proc_only_r <= 1'b0;
            prdata_r <= 32'h0000_0000;
            pslverr_r <= 1'b0;
            pready_r <= 1'b0;
        end else begin
            slow_d_r <= slow_d_nxt;
            mode_r <= mode_nxt;
            mode_locked_r <= mode_locked_nxt;
            count_r <= count_nxt;
            presc_r <= presc_nxt;
            stat_r <= stat_nxt;
            mask_r <= mask_nxt;
            fault_r <= fault_nxt;
            irq_r <= irq_nxt;
            proc_only_r <= proc_only_nxt;
            prdata_r <= prdata_nxt;
            pslverr_r <= pslverr_nxt;
            pready_r <= psel_i & penable_i & ~pready_r;
        end
    end

    assign prdata_o = prdata_r;
    assign pready_o = pready_r;
    assign pslverr_o = pslverr_r;
    assign irq_o = irq_r;
    assign fault_o = fault_r;
    assign fault_proc_only_o = proc_only_r;
endmodule

// File: tb/wwdt_slow_model.sv
// Slow clock source standing in for the clock generator
`timescale 1ns/1ps
module wwdt_slow_model (
    input wire logic clk_sys_i,
    input wire logic run_i,
    output logic slow_clk_o
);
    // Stands low while stopped, so no stray edge reaches the prescaler
    always_ff @(posedge clk_sys_i) begin
        slow_clk_o <= run_i ? ~slow_clk_o : 1'h0;
    end
endmodule

// File: tb/wwdt_asserts.sv
// Port checker of the windowed watchdog
`timescale 1ns/1ps
module wwdt_asserts (
    input wire logic clk_sys_i,
    input wire logic sys_rst_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [31:0] prdata_o,
    input wire logic pready_o,
    input wire logic pslverr_o,
    input wire logic irq_o,
    input wire logic fault_o,
    input wire logic fault_proc_only_o
);
    logic st_rd;
    logic ctl;
    assign ctl = paddr_i == wwdt_pkg::ADDR_RESTART_CONTROL;
    assign st_rd = psel_i && penable_i && pready_o && !pwrite_i
        && paddr_i == wwdt_pkg::ADDR_FAULT_STATUS;
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (sys_rst_i);
    // ------------------------------------------------------------
    // Sequences
    // ------------------------------------------------------------
    sequence acc_s;
        psel_i && penable_i && pready_o;
    endsequence
    sequence bad_key_s;
        acc_s ##0 (pwrite_i && ctl && pwdata_i[31:24] != wwdt_pkg::RESTART_KEY && !fault_o);
    endsequence
    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    access_wait_a: assert property (psel_i && penable_i && !pready_o |=> pready_o)
        else $error("pready late");
    ready_pulse_a: assert property (pready_o |=> !pready_o) else $error("pready long");
    read_idle_a: assert property (!pready_o |-> prdata_o == 32'h0) else $error("prdata idle");
    unmapped_err_a: assert property (acc_s |-> pslverr_o
        == (paddr_i > 8'h0C || paddr_i[1:0] != 2'h0))
        else $error("pslverr wrong");
    bad_key_a: assert property (bad_key_s |=> !fault_o) else $error("keyless fault");
    read_clear_a: assert property (st_rd |-> ##2 (!fault_o && !irq_o))
        else $error("status read kept fault");
    fault_hold_a: assert property (fault_o && !st_rd && !$past(st_rd) |=> fault_o)
        else $error("fault dropped");
    scope_hold_a: assert property (fault_o ##1 fault_o |-> $stable(fault_proc_only_o))
        else $error("scope moved");
    ctrl_read_a: assert property (acc_s ##0 (!pwrite_i && ctl) |-> prdata_o == 32'h0)
        else $error("control readable");
endmodule

// File: tb/windowed_watchdog_timer_bench.sv
// Self-checking bench of the windowed watchdog over APB
`timescale 1ns/1ps
module windowed_watchdog_timer_bench;
    localparam logic [7:0] CTL = wwdt_pkg::ADDR_RESTART_CONTROL;
    localparam logic [7:0] MD = wwdt_pkg::ADDR_WATCHDOG_MODE;
    localparam logic [7:0] ST = wwdt_pkg::ADDR_FAULT_STATUS;
    localparam logic [7:0] MK = wwdt_pkg::ADDR_IRQ_MASK;
    // Reload 4, window 2, irq and reset on, processor only, both halts on
    localparam logic [31:0] MODE_V = 32'h3002_7004;
    logic clk_sys_i = 1'h0;
    logic sys_rst_i = 1'h1;
    logic psel = 1'h0;
    logic pen = 1'h0;
    logic pwr = 1'h0;
    logic dbg = 1'h0;
    logic idle = 1'h0;
    logic run = 1'h0;
    logic [7:0] pa = 8'h00;
    logic [31:0] pwd = 32'h0;
    logic [31:0] prd;
    logic [31:0] rdat;
    logic rerr, slow, irq, flt, fpo, rdy, err;
    int num_errors = 0;
    int n_checks = 0;
    int cyc = 0;
    int n;
    always #5 clk_sys_i = ~clk_sys_i;
    wwdt_top dut (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .psel_i(psel),
        .penable_i(pen), .pwrite_i(pwr), .paddr_i(pa), .pwdata_i(pwd), .prdata_o(prd),
        .pready_o(rdy), .pslverr_o(err), .slow_clk_i(slow), .cpu_debug_i(dbg),
        .sys_idle_i(idle), .irq_o(irq), .fault_o(flt), .fault_proc_only_o(fpo));
    wwdt_slow_model far (.clk_sys_i(clk_sys_i), .run_i(run), .slow_clk_o(slow));
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            num_errors++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys_i);
        psel <= 1'h1;
        pwr <= w;
        pa <= a;
        pwd <= d;
        @(posedge clk_sys_i);
        pen <= 1'h1;
        @(posedge clk_sys_i);
        while (rdy !== 1'h1) begin
            @(posedge clk_sys_i);
        end
        rdat = prd;
        rerr = err;
        psel <= 1'h0;
        pen <= 1'h0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        apb(1'h0, a, 32'h0);
        chk("prdata", e, rdat);
    endtask
    // Lets registered outputs settle before they are looked at
    task automatic settle;
        repeat (3) @(posedge clk_sys_i);
        #1;
    endtask
    always @(posedge clk_sys_i) begin
        cyc++;
        if (cyc == 12000) begin
            num_errors++;
            end_of_test();
        end
    end
    initial begin
        repeat (10) @(posedge clk_sys_i);
        sys_rst_i <= 1'h0;
        rd(MD, wwdt_pkg::MODE_RESET);
        rd(ST, 32'h0);
        rd(MK, 32'h3);
        rd(CTL, 32'h0);
        rd(8'h10, 32'h0);
        chk("pslverr", 32'h1, 32'(rerr));
        apb(1'h1, MD, MODE_V);
        apb(1'h1, CTL, 32'h5A00_0001);
        rd(ST, 32'h0);
        apb(1'h1, CTL, 32'hA500_0001);
        settle();
        chk("irq", 32'h1, 32'(irq));
        chk("fault", 32'h1, 32'(flt));
        chk("scope", 32'h1, 32'(fpo));
        apb(1'h1, MK, 32'h0);
        settle();
        chk("irq", 32'h0, 32'(irq));
        apb(1'h1, MK, 32'h3);
        settle();
        chk("irq", 32'h1, 32'(irq));
        rd(ST, 32'h2);
        settle();
        chk("fault", 32'h0, 32'(flt));
        chk("irq", 32'h0, 32'(irq));
        rd(ST, 32'h0);
        apb(1'h1, MD, 32'h0000_8FFF);
        rd(MD, MODE_V);
        dbg <= 1'h1;
        run <= 1'h1;
        repeat (1500) @(posedge clk_sys_i);
        chk("fault", 32'h0, 32'(flt));
        dbg <= 1'h0;
        idle <= 1'h1;
        repeat (1500) @(posedge clk_sys_i);
        chk("fault", 32'h0, 32'(flt));
        idle <= 1'h0;
        repeat (900) @(posedge clk_sys_i);
        // Mode fields are left alone after this restart
        apb(1'h1, CTL, 32'hA500_0001);
        rd(ST, 32'h0);
        n = 0;
        while (flt !== 1'h1 && n < 3000) begin
            @(posedge clk_sys_i);
            n++;
        end
        // Five ticks of 256 cycles from the restart, less the status read
        chk("ticks", 32'h1, 32'(n >= 1265 && n <= 1295));
        settle();
        chk("irq", 32'h1, 32'(irq));
        rd(ST, 32'h1);
        run <= 1'h0;
        settle();
        chk("fault", 32'h0, 32'(flt));
        // Second reset in mid-run, then a disabled timer with all-resets scope
        @(posedge clk_sys_i);
        sys_rst_i <= 1'h1;
        repeat (3) @(posedge clk_sys_i);
        sys_rst_i <= 1'h0;
        run <= 1'h1;
        apb(1'h1, MD, 32'h0002_A004);
        repeat (1500) @(posedge clk_sys_i);
        rd(ST, 32'h0);
        apb(1'h1, CTL, 32'hA500_0001);
        settle();
        chk("irq", 32'h0, 32'(irq));
        chk("fault", 32'h1, 32'(flt));
        chk("scope", 32'h0, 32'(fpo));
        rd(ST, 32'h2);
        apb(1'h1, CTL, 32'hA500_0001);
        apb(1'h1, ST, 32'h2);
        rd(ST, 32'h0);
        end_of_test();
    end
endmodule
bind wwdt_top wwdt_asserts chk_i (.clk_sys_i, .sys_rst_i, .psel_i, .penable_i, .pwrite_i,
    .paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .irq_o, .fault_o, .fault_proc_only_o);
